// [hw/adc_three_wire_readout.sv]
// conversion timing and three-wire serial readout of a 16-bit converter
// assumes pins arrive asynchronously; sampleCode and ovClamp are on clk
// Functional notes
// [R01] turbo field set selects turbo readout
// [R02] turbo frame carries the previous result
// [R03] host holds data-in high while converting
// [R04] start edge begins conversion, releases output
// [R05] host waits quiet time before lowering start
// [R06] conversion end powers core down
// [R07] start fall shows MSB, falls shift
// [R08] no status: release after sixteenth fall
// [R09] status bits follow on falls 17-22
// [R10] release at last fall or start rise
// [R11] host leaves quiet time before next start
// [R12] started conversion always runs to completion
// [R13] non-busy host restores start high in time
// [R14] host keeps clock still during conversion
// [R15] busy modes need turbo off; default off
// [R16] busy mode: output released during conversion
// [R17] busy host holds start low through conversion
// [R18] busy mode drives output low at completion
// [R19] busy mode shifts result MSB first
// [R20] busy release after one extra fall
// [R21] host drives data-in for register writes
// [R22] status appended only when enabled
// [R23] status layout: clamp, span, highz, turbo
// [R24] register command: zero, rw, fixed pattern
// [R25] host clocks 16 or 22 falls; the bench host also clocks 23 in busy mode and 4 in a partial frame
`timescale 1ns/1ns
`default_nettype none
`include "adc_readout_params.svh"
module adc_three_wire_readout #(
  parameter int CONV_CYCLES = `ADC_CONV_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cnvPin,
  input  wire logic        sckPin,
  input  wire logic        sdiPin,
  input  wire logic        ovClamp,
  input  wire logic [15:0] sampleCode,
  output logic             sdoOut,
  output logic             sdoOe,
  output logic             coreOn,
  output logic             convDone,
  output logic             turboOn,
  output logic             statusOn,
  output logic [7:0]       cfgOut
);
  import adc_readout_pkg::*;

  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad
    $error("adc_three_wire_readout: CONV_CYCLES out of range");
  end

  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

  logic [2:0] pinLvl;
  logic [2:0] pinRise;
  logic [2:0] pinFall;
  logic       cnvLvl;
  logic       cnvRise;
  logic       cnvFall;
  logic       sckRise;
  logic       sckFall;
  logic       sdiLvl;

  conv_t       convSt_r;
  logic [15:0] timer_r;
  logic [15:0] result_r;
  logic        convEnd;

  rd_t         rdSt_r;
  logic [22:0] shift_r;
  logic [4:0]  bitCnt_r;
  logic [4:0]  frameLen_r;
  logic [4:0]  bitNxt;

  logic [15:0] rxSh_r;
  logic [4:0]  rxCnt_r;
  logic        rxStep_r;
  logic        regRdHit;
  logic        regWrHit;

  logic [7:0]  cfg_r;
  logic [5:0]  statBits;

  pin_sync #(
    .WIDTH   (3),
    .RST_VAL (`PIN_RST_VAL)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pinIn ({sdiPin, sckPin, cnvPin}),
    .level (pinLvl),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  assign cnvLvl  = pinLvl[0];
  assign cnvRise = pinRise[0];
  assign cnvFall = pinFall[0];
  assign sckRise = pinRise[1];
  assign sckFall = pinFall[1];
  assign sdiLvl  = pinLvl[2];

  // frame image, MSB first; busy frames lead with a low bit
  function automatic logic [22:0] frame_word(
    input logic [15:0] code,
    input logic [5:0]  st,
    input logic        busy
  );
    frame_word = busy ? {1'b0, code, st} : {code, st, 1'b0};
  endfunction

  function automatic logic [4:0] frame_len(
    input logic sten,
    input logic busy
  );
    frame_len = 5'(`ADC_DATA_BITS + (sten ? `ADC_STAT_BITS : 5'h00)
                + {4'h0, busy});
  endfunction

  function automatic logic cmd_ok(input logic [7:0] cmd);
    cmd_ok = !cmd[`CMD_WEN_BIT] && (cmd[5:0] == `CMD_PATTERN);
  endfunction

  // configuration and status view
  assign turboOn  = cfg_r[`CFG_TURBO];
  assign statusOn = cfg_r[`CFG_STAT_EN];
  assign statBits = {ovClamp, cfg_r[`CFG_SPAN], cfg_r[`CFG_HIZ],
                     cfg_r[`CFG_TURBO], 2'b00}; // [R23]

  always_comb begin
    cfgOut           = cfg_r;
    cfgOut[`CFG_OV]  = ovClamp;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_r <= `CFG_RESET; // [R15]
    end else if (regWrHit) begin
      cfg_r <= (rxSh_r[7:0] & `CFG_WR_MASK) | (cfg_r & ~`CFG_WR_MASK);
    end
  end

  // conversion timer; start edges during a conversion are ignored
  assign convEnd = (convSt_r == CONV_BUSY) && (timer_r == 16'h0000);
  assign coreOn  = (convSt_r == CONV_BUSY); // [R06]

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      convSt_r <= CONV_ACQ;
      timer_r  <= 16'h0000;
      result_r <= 16'h0000;
      convDone <= 1'b0;
    end else begin
      convDone <= 1'b0;
      case (convSt_r)
        CONV_ACQ: begin
          if (cnvRise) begin
            convSt_r <= CONV_BUSY; // [R04]
            timer_r  <= CONV_LAST;
          end
        end
        CONV_BUSY: begin
          if (timer_r == 16'h0000) begin
            convSt_r <= CONV_ACQ; // [R06]
            result_r <= sampleCode;
            convDone <= 1'b1;
          end else begin
            timer_r <= timer_r - 16'h0001; // [R12]
          end
        end
        default: convSt_r <= CONV_ACQ;
      endcase
    end
  end

  // readout shifter
  assign bitNxt = 5'(bitCnt_r + 5'h01);
  assign sdoOut = shift_r[22];
  assign sdoOe  = (rdSt_r == RD_DRIVE);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdSt_r     <= RD_IDLE;
      shift_r    <= 23'h00_0000;
      bitCnt_r   <= 5'h00;
      frameLen_r <= `ADC_DATA_BITS;
    end else if (cnvRise) begin
      bitCnt_r <= 5'h00;
      if (turboOn) begin
        rdSt_r     <= RD_ARMED; // [R01]
        shift_r    <= frame_word(result_r, statBits, 1'b0); // [R02]
        frameLen_r <= frame_len(statusOn, 1'b0); // [R22]
      end else begin
        rdSt_r <= RD_IDLE; // [R04] [R10] [R16] [R20]
      end
    end else if (convEnd && !turboOn) begin
      bitCnt_r   <= 5'h00;
      shift_r    <= frame_word(sampleCode, statBits, !cnvLvl); // [R19]
      frameLen_r <= frame_len(statusOn, !cnvLvl); // [R09]
      rdSt_r     <= cnvLvl ? RD_ARMED : RD_DRIVE; // [R18]
    end else if (cnvFall && rdSt_r == RD_ARMED) begin
      rdSt_r <= RD_DRIVE; // [R07]
    end else if (sckFall && rdSt_r == RD_DRIVE) begin
      shift_r  <= {shift_r[21:0], 1'b0}; // [R07]
      bitCnt_r <= bitNxt;
      if (bitNxt == frameLen_r) begin
        rdSt_r <= RD_IDLE; // [R08] [R10] [R20]
      end
    end else if (regRdHit && rdSt_r == RD_DRIVE) begin
      // keep the bit on show; the pending eighth fall brings the register MSB
      shift_r <= {shift_r[22], cfgOut, 14'h0000}; // [R24]
    end
  end

  // register command receiver on rising clock edges while start is low
  assign regRdHit = rxStep_r && (rxCnt_r == `CMD_BITS)
                    && cmd_ok(rxSh_r[7:0]) && rxSh_r[`CMD_RW_BIT]; // [R24]
  assign regWrHit = rxStep_r && (rxCnt_r == `CMD_FULL_BITS)
                    && cmd_ok(rxSh_r[15:8]) && !rxSh_r[14]; // [R24]

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxSh_r   <= 16'h0000;
      rxCnt_r  <= 5'h00;
      rxStep_r <= 1'b0;
    end else begin
      rxStep_r <= 1'b0;
      if (cnvFall) begin
        rxCnt_r <= 5'h00;
      end else if (sckRise && !cnvLvl && rxCnt_r != `CMD_FULL_BITS) begin
        rxSh_r   <= {rxSh_r[14:0], sdiLvl};
        rxCnt_r  <= 5'(rxCnt_r + 5'h01);
        rxStep_r <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  start_release_a: assert property (cnvRise |=> !sdoOe) // [R04]
    else $error("output still driven after start edge");

  conv_count_a: assert property ( // [R12]
    (convSt_r == CONV_BUSY && timer_r != 16'h0000)
    |=> convSt_r == CONV_BUSY && timer_r == $past(timer_r) - 16'h0001)
    else $error("conversion timer did not count down");

  core_down_a: assert property ( // [R06]
    convEnd |=> !coreOn && convDone && result_r == $past(sampleCode))
    else $error("core not powered down at conversion end");

  busy_hiz_a: assert property ( // [R16]
    (coreOn && !turboOn && $past(!turboOn)) |-> !sdoOe)
    else $error("output driven during non-turbo conversion");

  busy_low_a: assert property ( // [R18]
    (convEnd && !turboOn && !cnvLvl && !cnvRise) |=> sdoOe && !sdoOut)
    else $error("busy indication not driven low");

  frame_end_a: assert property ( // [R08] [R10] [R20]
    (sckFall && sdoOe && bitNxt == frameLen_r && !cnvRise && !convEnd)
    |=> !sdoOe)
    else $error("output not released at end of frame");

  turbo_prev_a: assert property ( // [R02]
    (cnvRise && turboOn) |=> shift_r[22:7] == $past(result_r))
    else $error("turbo frame not loaded with previous result");

  msb_first_a: assert property ( // [R07]
    (cnvFall && rdSt_r == RD_ARMED && !cnvRise && !convEnd)
    |=> sdoOe && sdoOut == $past(shift_r[22]))
    else $error("MSB not presented at start fall");

  status_word_a: assert property ( // [R23]
    (cnvRise && turboOn) |=> shift_r[6:1] == {$past(ovClamp), $past(cfg_r[`CFG_SPAN]),
    $past(cfg_r[`CFG_HIZ]), 3'b100})
    else $error("status bits wrongly placed");

  frame_len_a: assert property ( // [R09] [R22]
    (cnvRise && turboOn) |=> frameLen_r == ($past(statusOn) ? 5'h16 : 5'h10))
    else $error("frame length does not follow status enable");

  turbo_reset_a: assert property ($rose(rst_b) |-> !turboOn) // [R15]
    else $error("turbo not disabled after reset");

  cfg_write_a: assert property ( // [R24]
    regWrHit |=> cfg_r[`CFG_STAT_EN:`CFG_TURBO] == $past(rxSh_r[`CFG_STAT_EN:`CFG_TURBO])
    && cfg_r[0] == 1'b0 && cfg_r[7:5] == 3'b000)
    else $error("configuration write not applied");

  reg_read_a: assert property ( // [R24]
    (regRdHit && rdSt_r == RD_DRIVE && !cnvRise && !convEnd && !sckFall)
    |=> sdoOut == $past(sdoOut) && shift_r[21:14] == $past(cfgOut))
    else $error("register contents not loaded for readout");

  busy_data_a: assert property ( // [R19]
    (convEnd && !turboOn && !cnvLvl && !cnvRise)
    |=> shift_r[21:6] == $past(sampleCode) && frameLen_r == ($past(statusOn) ? 5'h17 : 5'h11))
    else $error("busy frame not loaded with new result");
endmodule
`default_nettype wire

// [hw/pin_sync.sv]
// two-flop synchroniser with registered edge detection per pin
// assumes pins are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  if (WIDTH < 1) begin : g_bad
    $error("pin_sync: WIDTH must be at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        meta_r[i]   <= RST_VAL[i];
        stable_r[i] <= RST_VAL[i];
        level[i]    <= RST_VAL[i];
        rise[i]     <= 1'b0;
        fall[i]     <= 1'b0;
      end else begin
        meta_r[i]   <= pinIn[i];
        stable_r[i] <= meta_r[i];
        level[i]    <= stable_r[i];
        rise[i]     <= stable_r[i] & ~level[i];
        fall[i]     <= ~stable_r[i] & level[i];
      end
    end
  end
endmodule
`default_nettype wire

// [shared/adc_readout_params.svh]
// constants for the three-wire converter readout block
// assumes a 100 MHz core clock; included by bare name
`ifndef ADC_READOUT_PARAMS_SVH
`define ADC_READOUT_PARAMS_SVH

`define ADC_CLK_MHZ       100
`define ADC_CONV_TIME_NS  300
`define ADC_CONV_CYCLES   ((`ADC_CONV_TIME_NS * `ADC_CLK_MHZ + 999) / 1000)

`define ADC_DATA_BITS     5'h10
`define ADC_STAT_BITS     5'h06
`define ADC_FRAME_W       23

`define CFG_OV            5
`define CFG_STAT_EN       4
`define CFG_SPAN          3
`define CFG_HIZ           2
`define CFG_TURBO         1
`define CFG_RESET         8'h00
`define CFG_WR_MASK       8'h1E

`define CMD_PATTERN       6'h14
`define CMD_RW_BIT        6
`define CMD_WEN_BIT       7
`define CMD_BITS          5'h08
`define CMD_FULL_BITS     5'h10

`define PIN_RST_VAL       3'h4

`endif

// [shared/adc_readout_pkg.sv]
// types shared by the converter readout block
// assumes nothing beyond a SystemVerilog compiler
package adc_readout_pkg;
  typedef enum logic [0:0] {
    CONV_ACQ  = 1'b0,
    CONV_BUSY = 1'b1
  } conv_t;

  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_ARMED = 2'b01,
    RD_DRIVE = 2'b10
  } rd_t;
endpackage

// [tb/spi_host_model.sv]
// host model driving start, serial clock and data-in of the converter
// assumes calls from the testbench; pins change on clk falling edges
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input  wire logic clk,
  input  wire logic sdoLine,
  output logic      cnvPin,
  output logic      sckPin,
  output logic      sdiPin
);
  localparam int QUIET = 6;
  initial begin
    cnvPin = 1'b0;
    sckPin = 1'b0; // clock still outside frames
    sdiPin = 1'b1; // data-in high while converting
  end
  // mode 0 non-busy, 1 busy indicator, 2 turbo
  task automatic start(input int mode);
    @(negedge clk);
    cnvPin = 1'b1;
    repeat (QUIET) @(negedge clk);
    if (mode == 1) begin
      cnvPin = 1'b0; // start low long before the end
    end else if (mode == 0) begin
      cnvPin = 1'b0;
      repeat (3) @(negedge clk);
      cnvPin = 1'b1; // early dip, back high in time
    end
  endtask
  task automatic select();
    repeat (QUIET) @(negedge clk); // quiet wait after start
    cnvPin = 1'b0;
  endtask
  task automatic frame(input int n, input logic [15:0] cmd, output logic [31:0] data);
    data = '0;
    for (int k = 0; k < n; k++) begin
      sdiPin = (k < 16) ? cmd[15-k] : 1'b1; // command zero, rw, pattern
      repeat (4) @(negedge clk);
      sckPin = 1'b1;
      repeat (4) @(negedge clk);
      data = {data[30:0], sdoLine};
      sckPin = 1'b0; // one fall per bit, n falls per frame
    end
    sdiPin = 1'b1;
    repeat (8) @(negedge clk); // quiet before next start
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the three-wire converter readout
// assumes the host model in spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int CONV = 30;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ovClamp = 1'b0;
  logic [15:0] sampleCode = 16'hA5C3;
  logic        cnvPin, sckPin, sdiPin, sdoOut, sdoOe, coreOn, convDone, turboOn, statusOn;
  logic [7:0]  cfgOut;
  logic [31:0] d;
  wire logic   sdoLine = sdoOe ? sdoOut : 1'b1;
  int          errCount = 0;
  int          checked = 0;
  int          coreCnt = 0;
  always #5 clk = ~clk;
  always @(negedge clk) if (coreOn === 1'b1) coreCnt++;
  adc_three_wire_readout #(.CONV_CYCLES(CONV)) adc_three_wire_readout_i (
    .clk(clk), .rst_b(rst_b), .cnvPin(cnvPin), .sckPin(sckPin), .sdiPin(sdiPin),
    .ovClamp(ovClamp), .sampleCode(sampleCode), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .coreOn(coreOn), .convDone(convDone), .turboOn(turboOn), .statusOn(statusOn), .cfgOut(cfgOut));
  spi_host_model spi_host_model_i (
    .clk(clk), .sdoLine(sdoLine), .cnvPin(cnvPin), .sckPin(sckPin), .sdiPin(sdiPin));
  task automatic endSim();
    $display("errors %0d checks %0d", errCount, checked);
    if (errCount == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conv(input int mode);
    int t;
    coreCnt = 0;
    spi_host_model_i.start(mode);
    if (mode != 0) chk(sdoOe, 0); // start edge releases output
    for (t = 0; t < 100 && convDone !== 1'b1; t++) begin
      @(negedge clk);
      if (mode == 1 && coreOn === 1'b1) chk(sdoOe, 0); // released while converting
    end
    if (t == 100) begin
      errCount++;
      endSim();
    end
    if (mode == 1) chk({sdoOe, sdoLine}, 2'b10); // busy flag drives low
    else chk(sdoOe, 0); // no drive at completion
    chk(coreCnt, CONV); // full conversion despite start dip
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk({sdoOe, coreOn, turboOn, statusOn, cfgOut}, 12'h000); // turbo off by default
    conv(0);
    spi_host_model_i.select();
    spi_host_model_i.frame(16, 16'hFFFF, d);
    chk(d, 16'hA5C3); // MSB on start fall, shift on falls
    chk(sdoOe, 0); // release after sixteenth fall
    sampleCode = 16'h3C96;
    conv(0);
    spi_host_model_i.select();
    spi_host_model_i.frame(16, 16'h1418, d);
    chk(d, 16'h3C96); // readout with write in the same frame
    ovClamp = 1'b1;
    @(negedge clk);
    chk({statusOn, cfgOut}, 9'h138); // status and span written
    sampleCode = 16'h5A0F;
    conv(0);
    spi_host_model_i.select();
    spi_host_model_i.frame(22, 16'hFFFF, d);
    chk(d, {16'h5A0F, 6'h30}); // status layout after result
    chk(sdoOe, 0); // release after final fall
    sampleCode = 16'hC3A5;
    conv(1);
    spi_host_model_i.frame(23, 16'hFFFF, d);
    chk(d, {1'b0, 16'hC3A5, 6'h30}); // busy low then MSB first
    chk(sdoOe, 0); // release after one extra fall
    sampleCode = 16'h0FF0;
    conv(0);
    spi_host_model_i.select();
    spi_host_model_i.frame(16, 16'h1402, d);
    chk(d, 16'h0FF0); // last non-turbo readout
    chk({turboOn, statusOn}, 2'b10); // turbo on, status off
    sampleCode = 16'h1234;
    conv(2);
    spi_host_model_i.select();
    spi_host_model_i.frame(16, 16'hFFFF, d);
    chk(d, 16'h0FF0); // turbo frame shows previous result
    chk(sdoOe, 0); // no status: release after sixteenth fall
    sampleCode = 16'h9999;
    conv(2);
    spi_host_model_i.select();
    spi_host_model_i.frame(4, 16'hFFFF, d);
    chk(d, 4'h1); // partial turbo frame of previous result
    conv(2);
    spi_host_model_i.select();
    spi_host_model_i.frame(16, 16'h54FF, d);
    chk(d, {8'h99, 8'h22}); // register read after command byte
    endSim();
  end
endmodule
`default_nettype wire
